//--- design/dic_cfg.svh
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH

// Channel count
`define DIC_NCH 8

// Register byte offsets
`define DIC_ADR_STATUS 8'h00
`define DIC_ADR_DRV 8'h04
`define DIC_ADR_FIRED 8'h08
`define DIC_ADR_CH_BASE 3'h1

// Channel config fields
`define DIC_CFG_CNT_LSB 0
`define DIC_CFG_CNT_MSB 7
`define DIC_CFG_INV_BIT 8
`define DIC_CFG_LVL_BIT 9
`define DIC_CFG_FN_LSB 12
`define DIC_CFG_FN_MSB 15

// Status fields
`define DIC_ST_PIN_LSB 0
`define DIC_ST_ACT_LSB 8
`define DIC_ST_DRV_BIT 16

// Reset values
`define DIC_CFG_RST 16'h0001
`define DIC_DRV_RST 1'h0

`endif

//--- design/dic_pkg.sv
`default_nettype none
package dic_pkg;
  typedef logic [7:0] dic_chvec_type;
  typedef logic [15:0] dic_cfg_type;
  typedef logic [7:0] dic_cnt_type;
  typedef logic [31:0] dic_word_type;
endpackage
`default_nettype wire

//--- design/dic_top.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`include "dic_cfg.svh"
`default_nettype none

// What this block does
// - Eight inputs each get their own conditioning path
// - Input one always acts as drive enable
// - Drive enabled only while input one high
// - Input one function still runs with gating
// - Activate only after counted asserted samples
// - Samples taken on variable background tick
// - Per-channel invert flips active level
// - Edge mode fires on state change
// - Level mode fires every sample while active
// - Each input holds function, count, invert, mode
module dic_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire dic_pkg::dic_word_type wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Input pins and background sample strobe
  input wire dic_pkg::dic_chvec_type din_i,
  input wire logic sample_tick_i,
  // Conditioned results
  output logic drive_en_o,
  output dic_pkg::dic_chvec_type ch_active_o,
  output dic_pkg::dic_chvec_type func_fire_o,
  output logic [31:0] func_sel_o
);
  import dic_pkg::*;

  dic_cfg_type ch_cfg_ff [`DIC_NCH];
  dic_cfg_type nxt_ch_cfg [`DIC_NCH];
  logic sw_en_ff;
  logic nxt_sw_en;
  dic_chvec_type fired_ff;
  dic_chvec_type nxt_fired;
  logic ack_ff;
  logic nxt_ack;
  dic_word_type rdat_ff;
  dic_word_type nxt_rdat;
  logic drv_ff;
  logic nxt_drv;
  dic_chvec_type pin_lvl;
  dic_chvec_type act_lvl;
  dic_chvec_type fire_lvl;
  logic wr_stb;
  logic ch_hit;
  logic [2:0] ch_idx;

  function automatic dic_cfg_type merge16(input dic_cfg_type old_v,
                                          input dic_word_type new_v,
                                          input logic [3:0] sel);
    dic_cfg_type r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign ch_hit = (wb_adr_i[7:5] == `DIC_ADR_CH_BASE);
  assign ch_idx = wb_adr_i[4:2];

  // Bus handshake and read mux
  always_comb begin
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdat = rdat_ff;
    if (nxt_ack) begin
      nxt_rdat = 32'h0000_0000;
      if (ch_hit) begin
        nxt_rdat[15:0] = ch_cfg_ff[ch_idx];
      end else begin
        unique case (wb_adr_i)
          `DIC_ADR_STATUS: begin
            nxt_rdat[`DIC_ST_PIN_LSB +: 8] = pin_lvl;
            nxt_rdat[`DIC_ST_ACT_LSB +: 8] = act_lvl;
            nxt_rdat[`DIC_ST_DRV_BIT] = drv_ff;
          end
          `DIC_ADR_DRV: begin
            nxt_rdat[0] = sw_en_ff;
          end
          `DIC_ADR_FIRED: begin
            nxt_rdat[7:0] = fired_ff;
          end
          default: begin
            nxt_rdat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'h0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Writes land on the edge after ack rises, as ack drops
  always_comb begin
    nxt_sw_en = sw_en_ff;
    nxt_fired = fired_ff;
    for (int i = 0; i < `DIC_NCH; i++) begin
      nxt_ch_cfg[i] = ch_cfg_ff[i];
    end
    if (wr_stb && ch_hit) begin
      nxt_ch_cfg[ch_idx] = merge16(ch_cfg_ff[ch_idx], wb_dat_i, wb_sel_i);
    end
    if (wr_stb && wb_adr_i == `DIC_ADR_DRV && wb_sel_i[0]) begin
      nxt_sw_en = wb_dat_i[0];
    end
    if (wr_stb && wb_adr_i == `DIC_ADR_FIRED && wb_sel_i[0]) begin
      nxt_fired = fired_ff & ~wb_dat_i[7:0];
    end
    // New fire beats a same-cycle clear
    nxt_fired = nxt_fired | fire_lvl;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_en_ff <= `DIC_DRV_RST;
      fired_ff <= 8'h00;
      for (int i = 0; i < `DIC_NCH; i++) begin
        ch_cfg_ff[i] <= `DIC_CFG_RST;
      end
    end else begin
      sw_en_ff <= nxt_sw_en;
      fired_ff <= nxt_fired;
      for (int i = 0; i < `DIC_NCH; i++) begin
        ch_cfg_ff[i] <= nxt_ch_cfg[i];
      end
    end
  end

  for (genvar g = 0; g < `DIC_NCH; g++) begin : g_ch
    dic_chan chan_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .din_i(din_i[g]),
      .tick_i(sample_tick_i),
      .cfg_i(ch_cfg_ff[g]),
      .pin_o(pin_lvl[g]),
      .act_o(act_lvl[g]),
      .fire_o(fire_lvl[g])
    );
    // Function select passes straight out of the setup word
    assign func_sel_o[4*g +: 4] = ch_cfg_ff[g][`DIC_CFG_FN_MSB:`DIC_CFG_FN_LSB];
  end

  // Synchronised, glitch-filtered level, not inverted or counted, so a drop disables without waiting for ticks
  always_comb begin
    nxt_drv = sw_en_ff & pin_lvl[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_ff <= 1'h0;
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign drive_en_o = drv_ff;
  assign ch_active_o = act_lvl;
  // channel zero fires like the rest
  assign func_fire_o = fire_lvl;

endmodule

// One conditioning path, instantiated once per channel
module dic_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin and background sample strobe
  input wire logic din_i,
  input wire logic tick_i,
  // Channel setup
  input wire dic_pkg::dic_cfg_type cfg_i,
  // Conditioned results
  output logic pin_o,
  output logic act_o,
  output logic fire_o
);
  import dic_pkg::*;

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic pin_ff;
  logic nxt_s1;
  logic nxt_s2;
  logic nxt_s3;
  logic nxt_pin;
  dic_cnt_type cnt_ff;
  dic_cnt_type nxt_cnt;
  dic_cnt_type thr;
  logic act_ff;
  logic nxt_act;
  logic fire_ff;
  logic nxt_fire;
  logic smp;

  // Change accepted once stages two and three agree
  // A one-cycle glitch never sits in both, so it is dropped
  always_comb begin
    nxt_s1 = din_i;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_pin = pin_ff;
    if (s2_ff == s3_ff) begin
      nxt_pin = s3_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 1'h0;
      s2_ff <= 1'h0;
      s3_ff <= 1'h0;
      pin_ff <= 1'h0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      pin_ff <= nxt_pin;
    end
  end

  always_comb begin
    thr = cfg_i[`DIC_CFG_CNT_MSB:`DIC_CFG_CNT_LSB];
    // Zero count behaves as one sample
    if (thr == 8'h00) begin
      thr = 8'h01;
    end
    smp = pin_ff ^ cfg_i[`DIC_CFG_INV_BIT];
    // Count saturates at the threshold, never wraps
    nxt_cnt = cnt_ff;
    nxt_act = act_ff;
    nxt_fire = 1'h0;
    if (tick_i) begin
      if (!smp) begin
        nxt_cnt = 8'h00;
        nxt_act = 1'h0;
      end else if (cnt_ff < thr) begin
        nxt_cnt = cnt_ff + 8'h01;
      end
      if (smp && nxt_cnt >= thr) begin
        nxt_act = 1'h1;
      end
      if (cfg_i[`DIC_CFG_LVL_BIT]) begin
        nxt_fire = nxt_act;
      end else begin
        nxt_fire = nxt_act ^ act_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
      act_ff <= 1'h0;
      fire_ff <= 1'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      act_ff <= nxt_act;
      fire_ff <= nxt_fire;
    end
  end

  assign pin_o = pin_ff;
  assign act_o = act_ff;
  assign fire_o = fire_ff;
endmodule

`default_nettype wire

//--- testbench/dic_top_sva.sv
`default_nettype none
module dic_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] din_i,
  input wire logic sample_tick_i,
  input wire logic drive_en_o,
  input wire logic [7:0] ch_active_o,
  input wire logic [7:0] func_fire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  drv_low_a: assert property (!din_i[0] [*6] |-> !drive_en_o)
    else $error("drive on, pin low");
  fire_tick_a: assert property (|func_fire_o |-> $past(sample_tick_i))
    else $error("fire off tick");
  act_tick_a: assert property ($changed(ch_active_o) |-> $past(sample_tick_i))
    else $error("state off tick");
  rise_fire_a: assert property (
    (ch_active_o & ~$past(ch_active_o) & ~func_fire_o) == 8'h00)
    else $error("rise, no fire");
  idle_fire_a: assert property (
    (func_fire_o & ~ch_active_o & ~$past(ch_active_o)) == 8'h00)
    else $error("idle fire");
endmodule
bind dic_top dic_top_sva chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .din_i,
  .sample_tick_i, .drive_en_o, .ch_active_o, .func_fire_o);
`default_nettype wire

//--- testbench/dic_pins.sv
`default_nettype none
module dic_pins (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] lvl_i,
  output logic [7:0] din_o,
  output logic tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff = 3'h0;
  always @(posedge clk_i) cnt_ff <= cnt_ff + 3'h1;
  assign tick_o = run_i && (cnt_ff == 3'h0 || cnt_ff == 3'h3);
  assign din_o = lvl_i;
endmodule
`default_nettype wire

//--- testbench/tb_dic_top.sv
`default_nettype none
module tb_dic_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, run = 1'h0, ack, drv, tick;
  logic [7:0] adr = 8'h00, lvl = 8'h00, din, act, fire;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, q, rdat, fsel;
  int error_cnt = 0;
  int n_tests = 0;
  int n_fire0 = 0;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h", $time, g); end end
  always #2 clk_i = ~clk_i;
  dic_pins pins_u (.clk_i, .run_i(run), .lvl_i(lvl), .din_o(din), .tick_o(tick));
  dic_top dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .din_i(din), .sample_tick_i(tick), .drive_en_o(drv), .ch_active_o(act),
    .func_fire_o(fire), .func_sel_o(fsel));
  // Edge-mode pulses of input one
  always @(posedge clk_i) begin
    if (fire[0] === 1'h1) n_fire0++;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    $display("CHECK FAILED %0t watchdog", $time);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    run <= 1'h1;
    @(posedge clk_i);
    bus(1'h0, 8'h20, 32'h0);
    `CHK(q, 32'h1)
    bus(1'h0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    bus(1'h1, 8'h20, 32'h7001);
    bus(1'h1, 8'h24, 32'h5003);
    bus(1'h1, 8'h28, 32'h0301);
    // Upper lanes masked: channel three function stays zero
    sel <= 4'h1;
    bus(1'h1, 8'h2C, 32'hFFC8);
    sel <= 4'hF;
    bus(1'h1, 8'h3C, 32'h0100);
    bus(1'h1, 8'h04, 32'h1);
    bus(1'h0, 8'h04, 32'h0);
    `CHK(q, 32'h1)
    `CHK(fsel, 32'h57)
    repeat (20) @(posedge clk_i);
    `CHK(act, 8'h84)
    bus(1'h1, 8'h08, 32'hFF);
    repeat (20) @(posedge clk_i);
    bus(1'h0, 8'h08, 32'h0);
    `CHK(q, 32'h4)
    lvl <= 8'h03;
    repeat (30) @(posedge clk_i);
    `CHK(drv, 1'h1)
    `CHK(act, 8'h87)
    bus(1'h0, 8'h00, 32'h0);
    `CHK(q, 32'h0001_8703)
    bus(1'h0, 8'h08, 32'h0);
    `CHK(q, 32'h7)
    lvl <= 8'h0A;
    repeat (10) @(posedge clk_i);
    `CHK(drv, 1'h0)
    repeat (490) @(posedge clk_i);
    `CHK(act[3], 1'h0)
    // Short dip must restart the long count
    lvl <= 8'h02;
    repeat (10) @(posedge clk_i);
    lvl <= 8'h0A;
    repeat (700) @(posedge clk_i);
    `CHK(act[3], 1'h0)
    repeat (400) @(posedge clk_i);
    `CHK(act, 8'h8E)
    `CHK(n_fire0, 2)
    give_verdict;
  end
endmodule
`default_nettype wire
